/* spm_pkg.sv */
// shared constants and types for the phase and modulus/reference word link
package spm_pkg;

   // word layout shared by both loadable registers
   localparam int unsigned WORD_W      = 32;
   localparam int unsigned CTL_LSB     = 0;            // control bits [2:0]
   localparam int unsigned CTL_W       = 3;
   localparam logic [2:0]  CTL_PHASE   = 3'h1;         // 001 loads phase
   localparam logic [2:0]  CTL_MODREF  = 3'h2;         // 010 loads mod/ref

   // phase register fields
   localparam int unsigned PHASE_LSB   = 3;            // DB14..DB3
   localparam int unsigned PHASE_W     = 12;

   // modulus/reference register fields
   localparam int unsigned MODE_LSB    = 29;           // DB30..DB29
   localparam int unsigned MODE_W      = 2;
   localparam int unsigned CSR_BIT     = 28;
   localparam int unsigned CP_LSB      = 24;           // DB27..DB24
   localparam int unsigned CP_W        = 4;
   localparam int unsigned PRESC_BIT   = 22;           // 1 selects 8/9
   localparam int unsigned HALVER_BIT  = 21;
   localparam int unsigned DOUBLER_BIT = 20;
   localparam int unsigned RDIV_LSB    = 15;           // DB19..DB15
   localparam int unsigned RDIV_W      = 5;
   localparam int unsigned MOD_LSB     = 3;            // DB14..DB3
   localparam int unsigned MOD_W       = 12;

   // integer divide width and limits per prescaler
   localparam int unsigned INT_W       = 16;
   localparam logic [15:0] NMIN_P45    = 16'h0017;     // 23
   localparam logic [15:0] NMIN_P89    = 16'h004B;     // 75

   // values after reset
   localparam logic [11:0] PHASE_RST   = 12'h001;      // recommended phase 1
   localparam logic [31:0] WORD_RST    = 32'h0000_0000;
   localparam logic [14:0] LFSR_SEED   = 15'h0001;

   // host register offsets
   localparam int unsigned ADDR_W      = 2;
   localparam logic [1:0]  OFS_PHASE   = 2'h0;
   localparam logic [1:0]  OFS_MODREF  = 2'h1;
   localparam logic [1:0]  OFS_CFG     = 2'h2;
   localparam logic [1:0]  OFS_STATUS  = 2'h3;

   // host configuration fields
   localparam int unsigned CFG_HIGH_BAND = 16;         // rf input above 3 GHz
   localparam int unsigned CFG_PD_NEG    = 17;         // detector polarity neg

   // host status bits
   localparam int unsigned ST_PHASE_ERR  = 0;
   localparam int unsigned ST_MODREF_ERR = 1;
   localparam int unsigned ST_MODREF_OK  = 2;

   // noise and spur modes
   typedef enum logic [1:0] {
      SPM_MODE_LOW_NOISE = 2'h0,
      SPM_MODE_RESERVED  = 2'h1,
      SPM_MODE_NOISE_SPUR = 2'h2,
      SPM_MODE_LOW_SPUR  = 2'h3
   } spm_mode_type;

endpackage : spm_pkg

/* spm_link_if.sv */
// parallel word link between host end and synthesizer configuration end
`timescale 1ns/1ps
`default_nettype none
interface spm_link_if (
   input wire logic ref_clk,
   input wire logic rst_n
);
   logic [31:0] word_data;   // full 32-bit register word
   logic        word_load;   // one-cycle strobe, word taken on this edge

   modport host   (output word_data, output word_load);
   modport device (input  word_data, input  word_load);
endinterface : spm_link_if
`default_nettype wire

/* spm_device.sv */
// configuration end: phase and modulus/reference registers and their use
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - control bits 001 load phase register
// - phase word is DB14..DB3, rest reserved
// - host keeps phase word below modulus
// - phase word sets output phase, 360/modulus steps
// - host should program phase one normally
// - control bits 010 load modulus/reference register
// - noise/spur mode from DB30..DB29
// - lowest spur mode enables interpolator dither
// - lowest noise disables dither, low-noise pump
// - cycle slip bit one enables reduction
// - host avoids slip reduction with negative polarity
// - pump current code from DB27..DB24
// - host picks 8/9 prescaler above 3 GHz
// - host keeps divide at or above 23 or 75
// - halver adds toggle stage before detector
// - DB20 one doubles reference before divider
// - falling edge only, doubler uses both edges
// - five-bit divider, ratios one through 32
// - twelve-bit fractional modulus held in register
// - host writes zero to reserved bits
// - host follows power-up register write order
module spm_device (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   // link to the host
   spm_link_if.device                  link,
   // reference and divider inputs from the rest of the synthesizer
   input  wire logic                   reference_input,
   input  wire logic [15:0]            int_value,
   input  wire logic [11:0]            fractional_numerator,
   // decoded configuration
   output logic      [11:0]            phase_word,
   output logic      [11:0]            fractional_modulus,
   output logic      [1:0]             noise_mode,
   output logic                        dither_en,
   output logic                        cp_low_noise_en,
   output logic                        cycle_slip_reduction,
   output logic      [3:0]             cp_current,
   output logic                        prescaler_89,
   output logic                        reference_halver,
   output logic                        doubler_en,
   output logic      [4:0]             ref_div_code,
   // detector reference tick and feedback divide value
   output logic                        pfd_ref_tick,
   output logic      [15:0]            divide_value
);

   ////////////////////////////////////////////////////////////////////////
   // word decode

   // true when the word's control bits carry the given code
   function automatic logic ctl_is(input logic [31:0] w,
                                   input logic [2:0]  code);
      ctl_is = (w[spm_pkg::CTL_LSB +: spm_pkg::CTL_W] == code);
   endfunction : ctl_is

   logic        load_phase;    // phase register write this cycle
   logic        load_modref;   // modulus/reference write this cycle
   logic [31:0] modref_ff;     // modulus/reference register image
   logic [11:0] phase_ff;      // phase word

   assign load_phase  = link.word_load &&
                        ctl_is(link.word_data, spm_pkg::CTL_PHASE);
   assign load_modref = link.word_load &&
                        ctl_is(link.word_data, spm_pkg::CTL_MODREF);

   ////////////////////////////////////////////////////////////////////////
   // registers

   // phase register: only DB14..DB3 are kept, reserved bits dropped
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff <= spm_pkg::PHASE_RST;
      end else if (load_phase) begin
         phase_ff <= link.word_data[spm_pkg::PHASE_LSB +:
                                    spm_pkg::PHASE_W];
      end
   end

   // modulus/reference register: whole word kept, fields sliced below
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         modref_ff <= spm_pkg::WORD_RST;
      end else if (load_modref) begin
         modref_ff <= link.word_data;
      end
   end

   // field slicing; outputs stay registered because modref_ff is a flop
   assign phase_word           = phase_ff;
   assign noise_mode           = modref_ff[spm_pkg::MODE_LSB +:
                                           spm_pkg::MODE_W];
   assign cycle_slip_reduction = modref_ff[spm_pkg::CSR_BIT];
   assign cp_current           = modref_ff[spm_pkg::CP_LSB +:
                                           spm_pkg::CP_W];
   assign prescaler_89         = modref_ff[spm_pkg::PRESC_BIT];
   assign reference_halver     = modref_ff[spm_pkg::HALVER_BIT];
   assign doubler_en           = modref_ff[spm_pkg::DOUBLER_BIT];
   assign ref_div_code         = modref_ff[spm_pkg::RDIV_LSB +:
                                           spm_pkg::RDIV_W];
   assign fractional_modulus   = modref_ff[spm_pkg::MOD_LSB +:
                                           spm_pkg::MOD_W];

   // mode decode: dither only in lowest spur, pump tuned in lowest noise
   assign dither_en       = (noise_mode ==
                             spm_pkg::SPM_MODE_LOW_SPUR);
   assign cp_low_noise_en = (noise_mode ==
                             spm_pkg::SPM_MODE_LOW_NOISE);

   ////////////////////////////////////////////////////////////////////////
   // reference path: edge select, divider, halver

   logic       ref_prev_ff;   // last sample of the reference input
   logic       ref_edge;      // active reference edge this cycle
   logic [4:0] rcnt_ff;       // reference divider count
   logic       r_tick;        // divider terminal count
   logic       half_ff;       // halver toggle stage
   logic       tick_pre;      // detector tick before the output flop
   logic       pfd_tick_ff;   // registered detector tick

   // previous reference level, for edge detection
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_prev_ff <= 1'b0;
      end else begin
         ref_prev_ff <= reference_input;
      end
   end

   // doubling modelled as counting both edges; without it only falling
   assign ref_edge = doubler_en ? (ref_prev_ff ^ reference_input)
                                : (ref_prev_ff & ~reference_input);

   // code n divides by n, code 0 wraps to 32 so the range is 1..32
   assign r_tick = ref_edge &&
                   (rcnt_ff == ref_div_code - 5'h01);

   // divider counter; a new register image restarts the count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rcnt_ff <= 5'h00;
      end else if (load_modref) begin
         rcnt_ff <= 5'h00;
      end else if (r_tick) begin
         rcnt_ff <= 5'h00;
      end else if (ref_edge) begin
         rcnt_ff <= rcnt_ff + 5'h01;
      end
   end

   // toggle stage between divider and detector
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_ff <= 1'b0;
      end else if (load_modref) begin
         half_ff <= 1'b0;
      end else if (r_tick) begin
         half_ff <= ~half_ff;
      end
   end

   // halver passes every second divider tick
   assign tick_pre = reference_halver ? (r_tick & half_ff)
                                      : r_tick;

   // detector tick output flop
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pfd_tick_ff <= 1'b0;
      end else begin
         pfd_tick_ff <= tick_pre;
      end
   end

   assign pfd_ref_tick = pfd_tick_ff;

   ////////////////////////////////////////////////////////////////////////
   // fractional interpolator

   logic [14:0] lfsr_ff;      // dither source
   logic [12:0] acc_ff;       // residue, kept below the modulus
   logic [12:0] sum;          // residue plus numerator plus dither
   logic        carry;        // residue overflowed this detector cycle
   logic [15:0] divide_ff;    // divide value for the next cycle

   // pseudo random bit stream, advanced once per detector tick
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_ff <= spm_pkg::LFSR_SEED;
      end else if (tick_pre) begin
         lfsr_ff <= {lfsr_ff[13:0], lfsr_ff[14] ^ lfsr_ff[13]};
      end
   end

   // dither nudges the residue so the carry pattern loses its period
   assign sum = acc_ff + {1'b0, fractional_numerator} +
                {12'h000, dither_en & lfsr_ff[0]};
   assign carry = (sum >= {1'b0, fractional_modulus});

   // the phase word seeds the residue, shifting output phase by
   // phase/modulus of a cycle; a residue seed at or above the modulus
   // simply carries on the first tick
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= 13'h0000;
      end else if (load_phase) begin
         acc_ff <= {1'b0, link.word_data[spm_pkg::PHASE_LSB +:
                                         spm_pkg::PHASE_W]};
      end else if (tick_pre) begin
         acc_ff <= carry ? (sum - {1'b0, fractional_modulus}) : sum;
      end
   end

   // mean of divide_value over many ticks is int + numerator/modulus when dither_en is low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         divide_ff <= 16'h0000;
      end else if (tick_pre) begin
         divide_ff <= int_value + {15'h0000, carry};
      end
   end

   assign divide_value = divide_ff;

endmodule : spm_device
`default_nettype wire

/* spm_host.sv */
// host end: builds and checks register words and sends them on the link
`timescale 1ns/1ps
`default_nettype none
module spm_host (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   // software register port
   input  wire logic [1:0]             addr,
   input  wire logic [31:0]            wr_data,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   output logic      [31:0]            rd_data,
   // link to the device
   spm_link_if.host                    link
);

   ////////////////////////////////////////////////////////////////////////
   // state

   logic [31:0] phase_sh_ff;    // last phase word accepted
   logic [31:0] modref_sh_ff;   // last mod/ref word accepted
   logic [31:0] cfg_ff;         // integer value and board facts
   logic [2:0]  status_ff;      // error flags and ordering flag
   logic [31:0] word_ff;        // word on the link
   logic        load_ff;        // link strobe
   logic [31:0] rd_ff;          // read data, one cycle after rd_en
   logic [31:0] phase_word;     // candidate phase word, reserved cleared
   logic [31:0] modref_word;    // candidate mod/ref word, reserved cleared
   logic        phase_bad;      // phase write refused
   logic        modref_bad;     // mod/ref write refused
   logic        wr_phase;
   logic        wr_modref;
   logic [15:0] nmin;

   assign wr_phase  = wr_en && (addr == spm_pkg::OFS_PHASE);
   assign wr_modref = wr_en && (addr == spm_pkg::OFS_MODREF);

   // reserved bits forced to zero and control bits forced to the code
   assign phase_word  = {17'h0_0000, wr_data[14:3],
                         spm_pkg::CTL_PHASE};
   assign modref_word = {1'b0, wr_data[30:24], 1'b0, wr_data[22:3],
                         spm_pkg::CTL_MODREF};

   // phase must sit below the modulus already sent, which also means
   // mod/ref must go first
   assign phase_bad = !status_ff[spm_pkg::ST_MODREF_OK] ||
                      (phase_word[14:3] >= modref_sh_ff[14:3]);

   assign nmin = modref_word[spm_pkg::PRESC_BIT] ? spm_pkg::NMIN_P89
                                                 : spm_pkg::NMIN_P45;

   // slip reduction needs positive polarity and minimum pump current;
   // 4/5 prescaler only below 3 GHz; integer at or above the prescaler floor
   assign modref_bad =
      (modref_word[spm_pkg::CSR_BIT] &&
       (cfg_ff[spm_pkg::CFG_PD_NEG] ||
        modref_word[27:24] != 4'h0)) ||
      (!modref_word[spm_pkg::PRESC_BIT] &&
       cfg_ff[spm_pkg::CFG_HIGH_BAND]) ||
      (cfg_ff[15:0] < nmin);

   ////////////////////////////////////////////////////////////////////////
   // shadows and configuration

   // phase shadow starts at the recommended value 1
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_sh_ff <= {17'h0_0000, spm_pkg::PHASE_RST,
                         spm_pkg::CTL_PHASE};
      end else if (wr_phase && !phase_bad) begin
         phase_sh_ff <= phase_word;
      end
   end

   // mod/ref shadow, needed for the phase check
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         modref_sh_ff <= spm_pkg::WORD_RST;
      end else if (wr_modref && !modref_bad) begin
         modref_sh_ff <= modref_word;
      end
   end

   // configuration register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= spm_pkg::WORD_RST;
      end else if (wr_en && addr == spm_pkg::OFS_CFG) begin
         cfg_ff <= {14'h0000, wr_data[17:0]};
      end
   end

   // status: error flags sticky, write one to clear, a new error wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= 3'h0;
      end else begin
         if (wr_en && addr == spm_pkg::OFS_STATUS) begin
            status_ff[1:0] <= status_ff[1:0] & ~wr_data[1:0];
         end
         if (wr_phase && phase_bad) begin
            status_ff[spm_pkg::ST_PHASE_ERR] <= 1'b1;
         end
         if (wr_modref && modref_bad) begin
            status_ff[spm_pkg::ST_MODREF_ERR] <= 1'b1;
         end
         if (wr_modref && !modref_bad) begin
            status_ff[spm_pkg::ST_MODREF_OK] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link and read port

   // an accepted word goes out one cycle after its write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_ff <= spm_pkg::WORD_RST;
         load_ff <= 1'b0;
      end else begin
         load_ff <= (wr_phase && !phase_bad) || (wr_modref && !modref_bad);
         if (wr_phase && !phase_bad) begin
            word_ff <= phase_word;
         end else if (wr_modref && !modref_bad) begin
            word_ff <= modref_word;
         end
      end
   end

   assign link.word_data = word_ff;
   assign link.word_load = load_ff;

   // read data valid only in the cycle after rd_en, zero otherwise
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ff <= spm_pkg::WORD_RST;
      end else if (rd_en) begin
         case (addr)
            spm_pkg::OFS_PHASE:  rd_ff <= phase_sh_ff;
            spm_pkg::OFS_MODREF: rd_ff <= modref_sh_ff;
            spm_pkg::OFS_CFG:    rd_ff <= cfg_ff;
            default:             rd_ff <= {29'h0, status_ff};
         endcase
      end else begin
         rd_ff <= spm_pkg::WORD_RST;
      end
   end

   assign rd_data = rd_ff;

endmodule : spm_host
`default_nettype wire

/* spm_link_assertions.sv */
// link checker: host-side word rules watched on the parallel link
`timescale 1ns/1ps
`default_nettype none
module spm_link_assertions (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // link signals
   input wire logic [31:0] word_data,
   input wire logic        word_load
);
   logic        seen_ff;   // a mod/ref word has gone out
   logic [11:0] mod_ff;    // modulus that phase words are judged against
   wire         ph = word_load && (word_data[2:0] == 3'h1);
   wire         mr = word_load && (word_data[2:0] == 3'h2);
   //////////////////////////////////////////////////////////////////////
   // track the last modulus; a reset forgets it, as the device does
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_ff <= 1'b0;
         mod_ff  <= 12'h000;
      end else if (mr) begin
         seen_ff <= 1'b1;
         mod_ff  <= word_data[14:3];
      end
   end
   //////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_code_valid: assert property (word_load |-> ph || mr)
      else $error("link word with unknown control code");
   chk_phase_reserved: assert property (
      ph |-> word_data[31:15] == 17'h0_0000)
      else $error("phase word with reserved bits set");
   chk_modref_reserved: assert property (
      mr |-> !word_data[31] && !word_data[23])
      else $error("mod/ref word with reserved bits set");
   chk_phase_order: assert property (ph |-> seen_ff)
      else $error("phase word sent before any mod/ref word");
   chk_phase_below_mod: assert property (
      ph |-> word_data[14:3] < mod_ff)
      else $error("phase word not below modulus");
   chk_slip_min_pump: assert property (
      mr && word_data[28] |-> word_data[27:24] == 4'h0)
      else $error("slip reduction sent without minimum pump current");
   chk_quiet_release: assert property (
      $rose(rst_n) |-> !word_load ##1 !word_load)
      else $error("link strobe right after reset release");
endmodule : spm_link_assertions
`default_nettype wire

/* tb_synth_phase_modulus_config.sv */
// self-checking bench: host end and configuration end joined by the link
`timescale 1ns/1ps
`default_nettype none
module tb_synth_phase_modulus_config;
   logic        ref_clk     = 1'b0;           // 200 MHz
   logic        rst_n       = 1'b0;
   int          miscompares = 0;
   int          n_tests     = 0;
   logic [1:0]  addr        = 2'h0;           // software port
   logic [31:0] wr_data     = 32'h0000_0000;
   logic        wr_en       = 1'b0;
   logic        rd_en       = 1'b0;
   logic [31:0] rd_data;
   logic        ref_in      = 1'b0;           // reference level
   logic [15:0] int_value   = 16'h0064;       // integer divide 100
   logic [11:0] fractional_numerator_num    = 12'h001;
   logic [11:0] phase_word;
   logic [11:0] fractional_modulus;
   logic [1:0]  noise_mode;
   logic        dither_en;
   logic        cp_low_noise_en;
   logic        cycle_slip_reduction;
   logic [3:0]  cp_current;
   logic        prescaler_89;
   logic        reference_halver;
   logic        doubler_en;
   logic [4:0]  ref_div_code;
   logic        pfd_ref_tick;
   logic [15:0] divide_value;
   always #2.5 ref_clk = ~ref_clk;
   //////////////////////////////////////////////////////////////////////
   spm_link_if spm_link_if_i (.ref_clk(ref_clk), .rst_n(rst_n));
   spm_host spm_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .link(spm_link_if_i));
   spm_device spm_device_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .link(spm_link_if_i), .reference_input(ref_in),
      .int_value(int_value), .fractional_numerator(fractional_numerator_num),
      .phase_word(phase_word), .fractional_modulus(fractional_modulus),
      .noise_mode(noise_mode), .dither_en(dither_en),
      .cp_low_noise_en(cp_low_noise_en),
      .cycle_slip_reduction(cycle_slip_reduction), .cp_current(cp_current),
      .prescaler_89(prescaler_89), .reference_halver(reference_halver),
      .doubler_en(doubler_en), .ref_div_code(ref_div_code),
      .pfd_ref_tick(pfd_ref_tick), .divide_value(divide_value));
   spm_link_assertions spm_link_assertions_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .word_data(spm_link_if_i.word_data),
      .word_load(spm_link_if_i.word_load));
   //////////////////////////////////////////////////////////////////////
   // mod/ref word with reserved bits zero and control code 010
   function automatic logic [31:0] mw(input logic [1:0] m, input logic c,
      input logic [3:0] cp, input logic p, h, d, input logic [4:0] r,
      input logic [11:0] md);
      return {1'b0, m, c, cp, 1'b0, p, h, d, r, md, 3'h2};
   endfunction : mw
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // one write strobe, then room for the link word to land
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge ref_clk);
      wr_en   <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, input logic [31:0] e,
                     input string what);
      @(posedge ref_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      check(what, e, rd_data);
   endtask : rd
   //////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      check("phase", 32'h0000_0001, phase_word);
      check("low noise", 32'h0000_0001, cp_low_noise_en);
      check("dither", 32'h0000_0000, dither_en);
      rd(2'h0, 32'h0000_0009, "phase shadow");
      wr(2'h0, 32'h0000_0011); // phase 2 before any mod/ref word
      check("early phase", 32'h0000_0001, phase_word);
      rd(2'h3, 32'h0000_0001, "status early");
      wr(2'h3, 32'h0000_0003);
   endtask : t_reset
   task automatic t_modref;
      logic [31:0] w;
      w = mw(2'h3, 1'b0, 4'h5, 1'b1, 1'b1, 1'b1, 5'h03, 12'h064);
      wr(2'h2, 32'h0000_0064);
      wr(2'h1, w);
      check("mode", 32'h0000_0003, noise_mode);
      check("dither", 32'h0000_0001, dither_en);
      check("pump", 32'h0000_0005, cp_current);
      check("fields", 32'h0000_00E3, {prescaler_89, reference_halver,
         doubler_en, ref_div_code});
      check("modulus", 32'h0000_0064, fractional_modulus);
      rd(2'h1, w, "modref shadow");
      for (int m = 0; m < 3; m++) begin
         wr(2'h1, mw(m[1:0], 1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 5'h01, 12'h064));
         check("dither", 32'h0000_0000, dither_en);
         check("low noise", {31'h0, m == 0}, cp_low_noise_en);
      end
   endtask : t_modref
   task automatic t_slip;
      wr(2'h1, mw(2'h0, 1'b1, 4'h0, 1'b1, 1'b0, 1'b0, 5'h01, 12'h064));
      check("slip on", 32'h0000_0001, cycle_slip_reduction);
      wr(2'h1, mw(2'h0, 1'b1, 4'h2, 1'b1, 1'b0, 1'b0, 5'h01, 12'h064));
      check("slip pump", 32'h0000_0000, cp_current);
      rd(2'h3, 32'h0000_0006, "status slip");
      wr(2'h3, 32'h0000_0003);
      wr(2'h2, 32'h0002_0064);
      wr(2'h1, mw(2'h0, 1'b1, 4'h0, 1'b1, 1'b0, 1'b0, 5'h01, 12'h064));
      rd(2'h3, 32'h0000_0006, "status polarity");
      wr(2'h3, 32'h0000_0003);
      wr(2'h1, mw(2'h0, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 5'h01, 12'h064));
      check("slip off", 32'h0000_0000, cycle_slip_reduction);
   endtask : t_slip
   task automatic t_presc;
      logic [31:0] cfg [5] = '{32'h0001_0064, 32'h0000_004A,
         32'h0000_004B, 32'h0000_0017, 32'h0000_0016};
      logic        p89 [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      logic        bad [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 5; i++) begin
         wr(2'h2, cfg[i]);
         wr(2'h1, mw(2'h0, 1'b0, 4'h0, p89[i], 1'b0, 1'b0, 5'h01, 12'h064));
         rd(2'h3, {29'h0, 1'b1, bad[i], 1'b0}, "presc");
         wr(2'h3, 32'h0000_0003);
      end
   endtask : t_presc
   task automatic t_phase;
      wr(2'h2, 32'h0000_0064);
      wr(2'h1, mw(2'h0, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 5'h01, 12'h064));
      wr(2'h0, 32'h0000_0319);
      check("phase 99", 32'h0000_0063, phase_word);
      wr(2'h0, 32'h0000_0321);
      check("phase 100", 32'h0000_0063, phase_word);
      rd(2'h3, 32'h0000_0005, "status phase");
      wr(2'h3, 32'h0000_0003);
   endtask : t_phase
   // count detector ticks over a burst of reference edges, modulus 4;
   // phase 3 seeds the residue, so the first tick already carries
   task automatic t_ticks(input logic d, h, input logic [4:0] r,
                          input int nfall, input int exp);
      int   got = 0;
      int   sum = 0;
      logic was = 1'b0;
      wr(2'h1, mw(2'h0, 1'b0, 4'h0, 1'b1, h, d, r, 12'h004));
      wr(2'h0, 32'h0000_0019);
      for (int i = 0; i < nfall * 8 + 8; i++) begin
         @(posedge ref_clk);
         if (i % 4 == 0 && i < nfall * 8) begin
            ref_in <= ~ref_in;
         end
         #1;
         if (was) begin
            sum += divide_value;
         end
         was = (pfd_ref_tick === 1'b1);
         got += was;
      end
      check("ticks", exp, got);
      check("divide sum", exp * 100 + (exp + 3) / 4, sum);
   endtask : t_ticks
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   //////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      t_reset();
      t_modref();
      t_slip();
      t_presc();
      t_phase();
      t_ticks(1'b0, 1'b0, 5'h02, 16, 8);
      t_ticks(1'b1, 1'b0, 5'h02, 16, 16);
      t_ticks(1'b0, 1'b1, 5'h02, 16, 4);
      t_ticks(1'b0, 1'b0, 5'h00, 32, 1);
      report_and_stop();
   end
endmodule : tb_synth_phase_modulus_config
`default_nettype wire
